// File: logic/iwd_pkg.sv
// shared constants and types for the instruction word decoder core
package iwd_pkg;
    localparam int IW_W = 14;
    localparam int PC_W = 11;
    localparam int FA_W = 7;
    localparam int DAT_W = 8;
    localparam int PHASES = 4;
    localparam int OSC_PERIOD_NS = 20;
    localparam int CYC_PER_INSTR = PHASES;
    localparam int INSTR_TIME_NS = CYC_PER_INSTR * OSC_PERIOD_NS;
    localparam logic [1:0] PH_READ = 2'h0;
    localparam logic [1:0] PH_CAPT = 2'h1;
    localparam logic [1:0] PH_EXEC = 2'h2;
    localparam logic [1:0] PH_FETCH = 2'h3;
    localparam logic [PC_W-1:0] RESET_PC = 11'h000;
    localparam logic [IW_W-1:0] NOP_WORD = 14'h0000;
    localparam logic [FA_W-1:0] PORT_A_ADDR = 7'h05;
    localparam logic [FA_W-1:0] FA_MAX = 7'h7F;
    localparam int GRP_MSB = 13;
    localparam int OP_MSB = 11;
    localparam int OP_LSB = 8;
    localparam int D_BIT = 7;
    localparam int B_MSB = 9;
    localparam int B_LSB = 7;
    localparam int K8_MSB = 7;
    localparam int K11_MSB = 10;
    localparam logic [7:0] CTL_RETURN = 8'h08;
    localparam logic [7:0] CTL_RETFIE = 8'h09;
    localparam logic [7:0] CTL_SLEEP = 8'h63;
    localparam logic [7:0] CTL_CLRWDT = 8'h64;
    localparam int ST_C = 0;
    localparam int ST_DC = 1;
    localparam int ST_Z = 2;
    localparam logic [2:0] STATUS_RESET = 3'h0;
    typedef enum logic [1:0] {GRP_BYTE, GRP_BIT, GRP_LIT} iwd_group_t;
endpackage

// File: logic/iwd_core.sv
// instruction word decoder and execution sequencer of the 8-bit core
`timescale 1ns/100ps
`default_nettype none
module iwd_core #(
    parameter int STACK_DEPTH = 8
) (
    input wire logic MCLK_IN,
    input wire logic RESETN_IN,
    input wire logic [iwd_pkg::IW_W-1:0] PM_DATA_IN,
    input wire logic [iwd_pkg::DAT_W-1:0] FR_RDATA_IN,
    input wire logic [iwd_pkg::DAT_W-1:0] PORT_PINS_IN,
    output logic [iwd_pkg::PC_W-1:0] PM_ADDR_OUT,
    output logic [iwd_pkg::FA_W-1:0] FR_ADDR_OUT,
    output logic FR_RD_OUT,
    output logic PORT_READ_OUT,
    output logic FR_WR_OUT,
    output logic [iwd_pkg::DAT_W-1:0] FR_WDATA_OUT,
    output logic [iwd_pkg::DAT_W-1:0] W_OUT,
    output logic [2:0] STATUS_OUT,
    output logic SLEEP_OUT,
    output logic CLRWDT_OUT
);
    localparam int SP_W = $clog2(STACK_DEPTH);

    logic [1:0] phase;
    logic [iwd_pkg::IW_W-1:0] ir;
    logic [iwd_pkg::DAT_W-1:0] opnd;
    logic [iwd_pkg::DAT_W-1:0] pin_s1;
    logic [iwd_pkg::DAT_W-1:0] pin_s2;
    logic [iwd_pkg::PC_W-1:0] stk [STACK_DEPTH];
    logic [SP_W-1:0] sp;

    iwd_pkg::iwd_group_t grp;
    logic [3:0] op;
    logic [iwd_pkg::FA_W-1:0] fadr;
    logic dsel;
    logic [2:0] bsel;
    logic [7:0] k8;
    logic [iwd_pkg::PC_W-1:0] k11;
    logic names_file;
    logic is_sub;
    logic [7:0] add_a;
    logic [7:0] add_b;
    logic [8:0] sum9;
    logic [4:0] sum5;
    logic [7:0] res;
    logic wr_file;
    logic wr_w;
    logic upd_z;
    logic upd_c;
    logic upd_dc;
    logic rot_c;
    logic skip;
    logic do_call;
    logic do_ret;
    logic do_goto;
    logic do_sleep;
    logic do_clrwdt;
    logic take_two;

    // field split; the group comes from the top two bits only
    always_comb begin
        fadr = ir[iwd_pkg::FA_W-1:0];
        dsel = ir[iwd_pkg::D_BIT];
        bsel = ir[iwd_pkg::B_MSB:iwd_pkg::B_LSB];
        k8 = ir[iwd_pkg::K8_MSB:0];
        k11 = ir[iwd_pkg::K11_MSB:0];
        op = ir[iwd_pkg::OP_MSB:iwd_pkg::OP_LSB];
        if (ir[iwd_pkg::GRP_MSB] == 1'h1) begin
            grp = iwd_pkg::GRP_LIT;
        end else if (ir[iwd_pkg::GRP_MSB-1] == 1'h1) begin
            grp = iwd_pkg::GRP_BIT;
        end else begin
            grp = iwd_pkg::GRP_BYTE;
        end
    end

    // every byte op with an f operand reads it, even clear and move-to-file
    assign names_file = (grp == iwd_pkg::GRP_BIT) ||
        ((grp == iwd_pkg::GRP_BYTE) && !(op[3:1] == 3'h0 && !dsel));
    assign is_sub = ((grp == iwd_pkg::GRP_BYTE) && op == 4'h2) ||
        ((grp == iwd_pkg::GRP_LIT) && ir[12:9] == 4'hE);
    assign add_a = (grp == iwd_pkg::GRP_LIT) ? k8 : opnd;
    assign add_b = is_sub ? ~W_OUT : W_OUT;
    assign sum9 = {1'h0, add_a} + {1'h0, add_b} + {8'h00, is_sub};
    assign sum5 = {1'h0, add_a[3:0]} + {1'h0, add_b[3:0]} + {4'h0, is_sub};
    assign take_two = skip || do_call || do_ret || do_goto;

    always_comb begin
        res = opnd;
        wr_file = 1'h0;
        wr_w = 1'h0;
        upd_z = 1'h0;
        upd_c = 1'h0;
        upd_dc = 1'h0;
        rot_c = 1'h0;
        skip = 1'h0;
        do_call = 1'h0;
        do_ret = 1'h0;
        do_goto = 1'h0;
        do_sleep = 1'h0;
        do_clrwdt = 1'h0;
        if (grp == iwd_pkg::GRP_BYTE) begin
            wr_file = dsel;
            wr_w = !dsel;
            upd_z = 1'h1;
            case (op)
                4'h0: begin
                    res = W_OUT;
                    upd_z = 1'h0;
                    wr_w = 1'h0;
                    // control words; unused low bits of the no-op form are ignored
                    if (!dsel) begin
                        do_ret = (k8 == iwd_pkg::CTL_RETURN) ||
                            (k8 == iwd_pkg::CTL_RETFIE);
                        do_sleep = (k8 == iwd_pkg::CTL_SLEEP);
                        do_clrwdt = (k8 == iwd_pkg::CTL_CLRWDT);
                    end
                end
                4'h1: res = 8'h00;
                4'h2, 4'h7: begin
                    res = sum9[7:0];
                    upd_c = 1'h1;
                    upd_dc = 1'h1;
                end
                4'h3, 4'hB: res = opnd - 8'h01;
                4'h4: res = opnd | W_OUT;
                4'h5: res = opnd & W_OUT;
                4'h6: res = opnd ^ W_OUT;
                4'h8: res = opnd;
                4'h9: res = ~opnd;
                4'hA, 4'hF: res = opnd + 8'h01;
                4'hC: begin
                    res = {STATUS_OUT[iwd_pkg::ST_C], opnd[7:1]};
                    rot_c = opnd[0];
                    upd_c = 1'h1;
                    upd_z = 1'h0;
                end
                4'hD: begin
                    res = {opnd[6:0], STATUS_OUT[iwd_pkg::ST_C]};
                    rot_c = opnd[7];
                    upd_c = 1'h1;
                    upd_z = 1'h0;
                end
                default: begin
                    res = {opnd[3:0], opnd[7:4]};
                    upd_z = 1'h0;
                end
            endcase
            if (op == 4'hB || op == 4'hF) begin
                upd_z = 1'h0;
                skip = (res == 8'h00);
            end
        end else if (grp == iwd_pkg::GRP_BIT) begin
            // only the selected bit of the register may change
            res[bsel] = op[2];
            wr_file = !op[3];
            if (op[3]) begin
                skip = (opnd[bsel] == op[2]);
            end
        end else if (ir[12] == 1'h0) begin
            do_call = !ir[11];
            do_goto = ir[11];
        end else begin
            wr_w = 1'h1;
            upd_z = 1'h1;
            if (ir[11:10] == 2'h0) begin
                res = k8;
                upd_z = 1'h0;
            end else if (ir[11:10] == 2'h1) begin
                res = k8;
                upd_z = 1'h0;
                do_ret = 1'h1;
            end else if (ir[11:8] == 4'h8) begin
                res = k8 | W_OUT;
            end else if (ir[11:8] == 4'h9) begin
                res = k8 & W_OUT;
            end else if (ir[11:8] == 4'hA) begin
                res = k8 ^ W_OUT;
            end else if (ir[11:9] == 3'h6 || ir[11:9] == 3'h7) begin
                res = sum9[7:0];
                upd_c = 1'h1;
                upd_dc = 1'h1;
            end else begin
                wr_w = 1'h0;
                upd_z = 1'h0;
            end
        end
    end

    // four oscillator periods per instruction cycle
    always_ff @(posedge MCLK_IN) begin
        if (!RESETN_IN) begin
            phase <= iwd_pkg::PH_READ;
        end else begin
            phase <= phase + 2'h1;
        end
    end

    // pins are asynchronous to the core clock
    always_ff @(posedge MCLK_IN) begin
        if (!RESETN_IN) begin
            pin_s1 <= 8'h00;
            pin_s2 <= 8'h00;
        end else begin
            pin_s1 <= PORT_PINS_IN;
            pin_s2 <= pin_s1;
        end
    end

    // file bus: read in the second phase, write in the last
    always_ff @(posedge MCLK_IN) begin
        if (!RESETN_IN) begin
            FR_ADDR_OUT <= 7'h00;
            FR_RD_OUT <= 1'h0;
            PORT_READ_OUT <= 1'h0;
            FR_WR_OUT <= 1'h0;
            FR_WDATA_OUT <= 8'h00;
            opnd <= 8'h00;
        end else begin
            FR_RD_OUT <= 1'h0;
            PORT_READ_OUT <= 1'h0;
            FR_WR_OUT <= 1'h0;
            if (phase == iwd_pkg::PH_READ) begin
                FR_ADDR_OUT <= fadr;
                FR_RD_OUT <= names_file;
                PORT_READ_OUT <= names_file && (fadr == iwd_pkg::PORT_A_ADDR);
            end
            if (phase == iwd_pkg::PH_CAPT && FR_RD_OUT) begin
                // port operands come from the pins so latch bits of inputs are not recycled
                if (FR_ADDR_OUT == iwd_pkg::PORT_A_ADDR) begin
                    opnd <= pin_s2;
                end else begin
                    opnd <= FR_RDATA_IN;
                end
            end
            if (phase == iwd_pkg::PH_EXEC) begin
                FR_WR_OUT <= wr_file;
                FR_WDATA_OUT <= res;
            end
        end
    end

    // accumulator, flags and control strobes
    always_ff @(posedge MCLK_IN) begin
        if (!RESETN_IN) begin
            W_OUT <= 8'h00;
            STATUS_OUT <= iwd_pkg::STATUS_RESET;
            SLEEP_OUT <= 1'h0;
            CLRWDT_OUT <= 1'h0;
        end else begin
            SLEEP_OUT <= 1'h0;
            CLRWDT_OUT <= 1'h0;
            if (phase == iwd_pkg::PH_EXEC) begin
                if (wr_w) begin
                    W_OUT <= res;
                end
                if (upd_z) begin
                    STATUS_OUT[iwd_pkg::ST_Z] <= (res == 8'h00);
                end
                if (upd_c) begin
                    STATUS_OUT[iwd_pkg::ST_C] <= (upd_dc ? sum9[8] : rot_c);
                end
                if (upd_dc) begin
                    STATUS_OUT[iwd_pkg::ST_DC] <= sum5[4];
                end
                SLEEP_OUT <= do_sleep;
                CLRWDT_OUT <= do_clrwdt;
            end
        end
    end

    // fetch: the word at PM_ADDR_OUT is taken at the end of each cycle
    always_ff @(posedge MCLK_IN) begin
        if (!RESETN_IN) begin
            PM_ADDR_OUT <= iwd_pkg::RESET_PC;
            ir <= iwd_pkg::NOP_WORD;
            sp <= '0;
        end else if (phase == iwd_pkg::PH_FETCH) begin
            // the prefetched word is squashed into a no-op second cycle
            ir <= take_two ? iwd_pkg::NOP_WORD : PM_DATA_IN;
            if (do_call || do_goto) begin
                PM_ADDR_OUT <= k11;
            end else if (do_ret) begin
                PM_ADDR_OUT <= stk[sp - SP_W'(1)];
            end else begin
                PM_ADDR_OUT <= PM_ADDR_OUT + 11'h001;
            end
            // the stack wraps silently on overflow, as a small hardware stack does
            if (do_call) begin
                stk[sp] <= PM_ADDR_OUT;
                sp <= sp + SP_W'(1);
            end else if (do_ret) begin
                sp <= sp - SP_W'(1);
            end
        end
    end

    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (!RESETN_IN);

    sequence s_rest_of_cycle;
        $stable(PM_ADDR_OUT) [*3];
    endsequence
    sequence s_quiet_cycle;
        (!FR_RD_OUT && !FR_WR_OUT && !SLEEP_OUT) [*4];
    endsequence

    property p_fetch_once_per_cycle;
        (phase == iwd_pkg::PH_READ) |=> s_rest_of_cycle;
    endproperty
    a_fetch_once_per_cycle: assert property (p_fetch_once_per_cycle) else $error("pc moved mid-cycle");

    // reset is the antecedent here, so the default reset gate must not swallow it
    property p_reset_start;
        @(posedge MCLK_IN) disable iff (1'b0)
            !RESETN_IN |=> (phase == iwd_pkg::PH_READ && PM_ADDR_OUT == iwd_pkg::RESET_PC);
    endproperty
    a_reset_start: assert property (p_reset_start) else $error("bad reset state");

    property p_write_after_read;
        FR_WR_OUT |-> ($past(FR_RD_OUT, 2) && $past(FR_ADDR_OUT, 2) == FR_ADDR_OUT);
    endproperty
    a_write_after_read: assert property (p_write_after_read) else $error("write without read");

    property p_dest_select;
        (FR_WR_OUT && grp == iwd_pkg::GRP_BYTE) |-> (dsel == 1'h1);
    endproperty
    a_dest_select: assert property (p_dest_select) else $error("file write with d clear");

    property p_one_bit_only;
        (FR_WR_OUT && grp == iwd_pkg::GRP_BIT) |->
            (((FR_WDATA_OUT ^ opnd) & ~(8'h01 << bsel)) == 8'h00);
    endproperty
    a_one_bit_only: assert property (p_one_bit_only) else $error("bit op touched other bits");

    property p_squash;
        (phase == iwd_pkg::PH_FETCH && take_two) |=> s_quiet_cycle;
    endproperty
    a_squash: assert property (p_squash) else $error("squashed word had effect");

    property p_branch_two_cycles;
        (phase == iwd_pkg::PH_READ && grp == iwd_pkg::GRP_LIT && !ir[12]) |->
            ##3 take_two ##1 (ir == iwd_pkg::NOP_WORD);
    endproperty
    a_branch_two_cycles: assert property (p_branch_two_cycles) else $error("branch not two cycles");

    property p_port_from_pins;
        (FR_RD_OUT && FR_ADDR_OUT == iwd_pkg::PORT_A_ADDR) |=> (opnd == $past(pin_s2));
    endproperty
    a_port_from_pins: assert property (p_port_from_pins) else $error("port operand not from pins");

    property p_port_read_effect;
        (FR_RD_OUT && FR_ADDR_OUT == iwd_pkg::PORT_A_ADDR) == PORT_READ_OUT;
    endproperty
    a_port_read_effect: assert property (p_port_read_effect) else $error("port read strobe missing");

    property p_goto_target;
        (phase == iwd_pkg::PH_FETCH && do_goto) |=> (PM_ADDR_OUT == $past(k11));
    endproperty
    a_goto_target: assert property (p_goto_target) else $error("goto target wrong");
endmodule
`default_nettype wire

// File: sim/iwd_mem_model.sv
// program memory and file register model facing the decoder core
`timescale 1ns/100ps
`default_nettype none
module iwd_mem_model (
    input wire logic clk_in,
    input wire logic [iwd_pkg::PC_W-1:0] pm_addr_in,
    input wire logic [iwd_pkg::FA_W-1:0] fr_addr_in,
    input wire logic fr_rd_in,
    input wire logic fr_wr_in,
    input wire logic [iwd_pkg::DAT_W-1:0] fr_wdata_in,
    output logic [iwd_pkg::IW_W-1:0] pm_data_out,
    output logic [iwd_pkg::DAT_W-1:0] fr_rdata_out
);
    logic [iwd_pkg::IW_W-1:0] prog [0:2047];
    logic [iwd_pkg::DAT_W-1:0] fmem [0:127];
    assign pm_data_out = prog[pm_addr_in];
    // outside a read strobe the data shows the inverse, so a late sample is caught
    assign fr_rdata_out = fr_rd_in ? fmem[fr_addr_in] : ~fmem[fr_addr_in];
    always @(posedge clk_in) begin
        if (fr_wr_in) begin
            fmem[fr_addr_in] <= fr_wdata_in;
        end
    end
endmodule
`default_nettype wire

// File: sim/tb_iwd_core.sv
// self-checking bench for the instruction word decoder core
`timescale 1ns/100ps
`default_nettype none
module tb_iwd_core;
    localparam int LIMIT = 1000;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] pins = 8'h00;
    logic [13:0] pm_data;
    logic [7:0] fr_rdata;
    logic [10:0] pm_addr;
    logic [6:0] fr_addr;
    logic fr_rd, port_rd, fr_wr;
    logic [7:0] fr_wdata, w_out;
    logic [2:0] status;
    logic sleep_p, wdt_p;
    logic [31:0] seed = 32'h5f3b_4728;
    logic [22:0] exp_q [$];
    logic [22:0] note;
    int num_errors = 0;
    int cmp_count = 0;
    int clk_n = 0;
    int base_clk = 0;
    int rd_cnt = 0;
    int port_cnt = 0;
    int sleep_cnt = 0;
    int wdt_cnt = 0;

    iwd_core dut_u (
        .MCLK_IN(mclk), .RESETN_IN(resetn), .PM_DATA_IN(pm_data),
        .FR_RDATA_IN(fr_rdata), .PORT_PINS_IN(pins), .PM_ADDR_OUT(pm_addr),
        .FR_ADDR_OUT(fr_addr), .FR_RD_OUT(fr_rd), .PORT_READ_OUT(port_rd),
        .FR_WR_OUT(fr_wr), .FR_WDATA_OUT(fr_wdata), .W_OUT(w_out),
        .STATUS_OUT(status), .SLEEP_OUT(sleep_p), .CLRWDT_OUT(wdt_p)
    );
    iwd_mem_model m (
        .clk_in(mclk), .pm_addr_in(pm_addr), .fr_addr_in(fr_addr), .fr_rd_in(fr_rd),
        .fr_wr_in(fr_wr), .fr_wdata_in(fr_wdata), .pm_data_out(pm_data),
        .fr_rdata_out(fr_rdata)
    );

    initial begin
        forever #10 mclk = ~mclk;
    end

    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        cmp_count++;
        if (got !== want) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, want);
        end
    endtask

    task automatic put(input logic [7:0] cyc, input logic [6:0] a, input logic [7:0] d);
        exp_q.push_back({cyc, a, d});
    endtask

    task give_verdict();
        if (num_errors == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // one pass: reset, load a program, note every file write with its instruction cycle
    task automatic run_pass();
        logic [7:0] k, s2, w, pv, k2;
        logic [6:0] pa, fm;
        logic [13:0] p [0:25];
        pa = iwd_pkg::PORT_A_ADDR;
        fm = iwd_pkg::FA_MAX;
        seed = xs(seed);
        k = seed[7:0];
        pv = seed[15:8];
        k2 = seed[23:16];
        s2 = k + k;
        w = k + s2;
        @(posedge mclk);
        resetn <= 1'b0;
        pins <= pv;
        // tail: call a subtract-literal routine, return, store W, then sleep and clear-watchdog
        p = '{{6'h33, k}, {7'h01, fm}, {7'h0F, fm}, {7'h0E, fm}, {7'h01, 7'h10},
            {4'h5, 3'd7, 7'h10}, {4'h4, 3'd0, 7'h10}, {7'h11, pa}, {7'h03, pa},
            {3'b101, 11'd12}, {7'h01, 7'h20}, {7'h01, 7'h20}, {6'h30, 8'h01},
            {7'h01, 7'h21}, {7'h17, 7'h21}, {7'h01, 7'h22}, {7'h01, 7'h23},
            {3'h4, 11'h018}, {7'h01, 7'h24}, 14'h0063, 14'h0064, {3'h5, 11'h015},
            {7'h01, 7'h22}, {7'h01, 7'h22}, {6'h3C, k2}, 14'h0008};
        for (int i = 0; i < 26; i++) begin
            m.prog[i] = p[i];
        end
        // latch differs from the pins so a read of the latch shows up
        m.fmem[pa] = ~pv;
        rd_cnt = 0;
        port_cnt = 0;
        sleep_cnt = 0;
        wdt_cnt = 0;
        put(2, fm, k);
        put(3, fm, s2);
        put(5, 7'h10, w);
        put(6, 7'h10, w | 8'h80);
        put(7, 7'h10, (w | 8'h80) & 8'hFE);
        put(8, pa, pv);
        put(9, pa, 8'h00);
        put(13, 7'h21, 8'h01);
        put(14, 7'h21, 8'h00);
        put(16, 7'h23, 8'h01);
        put(22, 7'h24, k2 - 8'h01);
        repeat (6) @(posedge mclk);
        resetn <= 1'b1;
        #1;
        chk(pm_addr, iwd_pkg::RESET_PC);
        for (int i = 0; i < 200 && exp_q.size() != 0; i++) begin
            @(posedge mclk);
        end
        repeat (12) @(posedge mclk);
        #1;
        chk(exp_q.size(), 0);
        chk(rd_cnt, 12);
        chk(port_cnt, 2);
        chk(w_out, 8'(k2 - 8'h01));
        chk(status, {k2 == 8'h01, k2[3:0] != 4'h0, k2 != 8'h00});
        chk(sleep_cnt, 1);
        chk(wdt_cnt, 1);
    endtask

    always @(posedge mclk) begin
        clk_n++;
        if (fr_rd === 1'b1) begin
            rd_cnt++;
        end
        if (port_rd === 1'b1) begin
            port_cnt++;
        end
        if (sleep_p === 1'b1) begin
            sleep_cnt++;
        end
        if (wdt_p === 1'b1) begin
            wdt_cnt++;
        end
        if (fr_wr === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk({fr_addr, fr_wdata}, 32'hFFFF_FFFF);
            end else begin
                note = exp_q.pop_front();
                if (note[22:15] == 8'd2) begin
                    base_clk = clk_n;
                end
                chk({fr_addr, fr_wdata}, note[14:0]);
                chk(clk_n - base_clk, iwd_pkg::PHASES * (note[22:15] - 2));
            end
        end
    end

    // a hung core never empties the queue; cut the run short
    always @(posedge mclk) begin
        if (clk_n >= LIMIT) begin
            num_errors++;
            give_verdict();
        end
    end

    initial begin
        repeat (2) run_pass();
        give_verdict();
    end
endmodule
`default_nettype wire
